// [spm_defines.vh]
// Constants of the serial master/slave port: register indices, bit positions,
// reset values and rate generator half periods.
// Assumes it is included by its bare name from every design file that needs it.
`ifndef SPM_DEFINES_VH
`define SPM_DEFINES_VH

// Register indices; the byte address on APB is four times the index.
`define SPM_IDX_CTRL 6'h10
`define SPM_IDX_STAT 6'h11
`define SPM_IDX_DATA 6'h12

// Bit positions in port_control.
`define SPM_C_RXIE 7
`define SPM_C_MSTR 5
`define SPM_C_CLOCK_POLARITY 4
`define SPM_C_CLOCK_PHASE 3
`define SPM_C_WOM 2
`define SPM_C_EN 1
`define SPM_C_TXIE 0

// Bit positions in port_status_and_control.
`define SPM_S_RXF 7
`define SPM_S_ERROR_IRQ_ENABLE 6
`define SPM_S_OVR 5
`define SPM_S_MODE_FAULT_FLAG 4
`define SPM_S_TXE 3
`define SPM_S_MODE_FAULT_ENABLE 2
`define SPM_S_RATE_HI 1
`define SPM_S_RATE_LO 0

// Reset values.
`define SPM_CTRL_RESET 8'h28
`define SPM_STAT_RESET 8'h08

// Half periods of the master serial clock in bus cycles: dividers 2, 8, 32, 128.
`define SPM_HALF_DIV2 7'h01
`define SPM_HALF_DIV8 7'h04
`define SPM_HALF_DIV32 7'h10
`define SPM_HALF_DIV128 7'h40

// Index of the last bit in one transfer.
`define SPM_LAST_BIT 3'h7

`endif

// [spm_port.v]
// Full-duplex byte serial port, master or slave, with an APB register slave.
// Assumes pins are synchronous to core_clk and a testbench resolves the wires.
//
// How it works
// - master_select one makes the port master.
// - master_select zero makes it slave on pin clock.
// - master starts a byte on data write.
// - write to idle shifter loads it, tx empty.
// - master shifts MISO in while shifting MOSI.
// - rate bits choose bus clock over 2..128.
// - master end sets rx full, copies byte.
// - rx full clears by status then data read.
// - data write clears tx interrupt enable.
// - slave byte done moves to rx, sets full.
// - slave clock is independent of rate bits.
// - slave sends shifter; late writes resend old.
// - separate rx and tx interrupt requests, plus errors.
// - separate tx and rx buffers beside shifter.
// - master rate generator drives the clock pin.
// - slave starts on select fall or first edge.
// - unread rx buffer means overrun, drop byte.
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`include "spm_defines.vh"

module spm_port (
  input wire core_clk,
  input wire reset_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire sckIn,
  output wire sckOut,
  output wire sckOe,
  input wire mosiIn,
  output wire mosiOut,
  output wire mosiOe,
  input wire misoIn,
  output wire misoOut,
  output wire misoOe,
  input wire slaveSelect_n,
  output wire rxIrq,
  output wire txIrq
);

  // Reset images of the two control words, unpacked bit by bit below.
  localparam [7:0] CTRL_INIT = `SPM_CTRL_RESET;
  localparam [7:0] STAT_INIT = `SPM_STAT_RESET;
  // Control and status bits.
  reg rxIe, mstr, clock_polarity, clock_phase, wom, en, txIe;
  reg error_irq_enable, mode_fault_enable;
  reg [1:0] rateSel;
  reg rxFull, ovr, mode_fault_flag, txPending;
  reg rxArm, ovrArm, modfArm;
  // Data path.
  reg [7:0] rxBuf, txBuf, shifter;
  reg inLatch, outBit, active, sckAct, sckPrev, ssPrev;
  reg [2:0] bitCnt;
  wire halfTick;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode. The slave answers with no wait states.
  wire [5:0] idx = paddr[7:2];
  wire hitCtrl = (idx == `SPM_IDX_CTRL);
  wire hitStat = (idx == `SPM_IDX_STAT);
  wire hitData = (idx == `SPM_IDX_DATA);
  wire mapped = hitCtrl | hitStat | hitData;
  wire apbWr = psel & penable & pwrite;
  wire apbRd = psel & penable & ~pwrite;
  wire wrCtrl = apbWr & hitCtrl;
  wire wrStat = apbWr & hitStat;
  wire wrData = apbWr & hitData;
  wire rdStat = apbRd & hitStat;
  wire rdData = apbRd & hitData;

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  ////////////////////////////////////////////////////////////////////////////
  // Read data is captured in the setup cycle so it comes from a flip-flop.
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable) begin
      case (idx)
        `SPM_IDX_CTRL: prdata <= {24'h000000, rxIe, 1'b0, mstr, clock_polarity, clock_phase, wom, en, txIe};
        `SPM_IDX_STAT: prdata <= {24'h000000, rxFull, error_irq_enable, ovr, mode_fault_flag, ~txPending,
                                  mode_fault_enable, rateSel};
        `SPM_IDX_DATA: prdata <= {24'h000000, rxBuf};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rate generator, only running for an enabled master.
  spm_rate_gen u_rate (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .run(en & mstr),
    .rateSel(rateSel),
    .halfTick(halfTick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock edges. Master edges come from the rate generator; slave
  // edges from the pin, compared against the idle level set by polarity.
  // Because the pin is sampled once per bus cycle, each pin level must stand
  // at least one bus cycle.
  wire mLead = mstr & active & halfTick & ~sckAct;
  wire mTrail = mstr & active & halfTick & sckAct;
  wire sEnabled = en & ~mstr & ~slaveSelect_n;
  wire sLeadRaw = sEnabled & (sckPrev == clock_polarity) & (sckIn != clock_polarity);
  wire sTrailRaw = sEnabled & (sckPrev != clock_polarity) & (sckIn == clock_polarity);
  wire ssFall = en & ~mstr & ssPrev & ~slaveSelect_n;
  // Slave start: select fall for phase zero, first clock edge for phase one.
  wire slaveStart = clock_phase ? (sLeadRaw & ~active) : ssFall;
  wire lead = mstr ? mLead : (sLeadRaw & (active | clock_phase));
  wire trail = mstr ? mTrail : (sTrailRaw & active);
  // Master samples MISO, slave samples MOSI.
  wire inBit = mstr ? misoIn : mosiIn;
  wire sampled = clock_phase ? inBit : inLatch;
  wire [7:0] rxByte = {shifter[6:0], sampled};
  wire done = trail & (bitCnt == `SPM_LAST_BIT);

  // Loading the shifter: a write to an idle shifter goes straight in, else
  // the queued byte follows as soon as the shifter is free.
  wire directLoad = en & wrData & ~active & ~txPending;
  wire queuedLoad = en & ~active & txPending & ~done;
  wire loadNow = directLoad | queuedLoad;
  wire [7:0] loadByte = directLoad ? pwdata[7:0] : txBuf;

  // A master with its select pin pulled low sees a contending master.
  wire modfEvent = en & mstr & mode_fault_enable & ~slaveSelect_n;

  ////////////////////////////////////////////////////////////////////////////
  // Pin edge history. Pins are synchronous, so one stage is enough.
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sckPrev <= 1'b0;
      ssPrev <= 1'b1;
    end else begin
      sckPrev <= sckIn;
      ssPrev <= slaveSelect_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift engine. Phase zero samples on the leading edge and shifts on the
  // trailing; phase one presents a bit on the leading edge and shifts the
  // sample in on the trailing. Either way the byte ends on the eighth
  // trailing edge.
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      shifter <= 8'h00;
      inLatch <= 1'b0;
      outBit <= 1'b0;
      active <= 1'b0;
      sckAct <= 1'b0;
      bitCnt <= 3'h0;
    end else if (!en) begin
      active <= 1'b0;
      sckAct <= 1'b0;
      bitCnt <= 3'h0;
    end else if (loadNow) begin
      shifter <= loadByte;
      active <= mstr;
      sckAct <= 1'b0;
      bitCnt <= 3'h0;
    end else if (~mstr & ~clock_phase & slaveSelect_n) begin
      // Phase zero needs the select toggled between bytes; a rise aborts.
      active <= 1'b0;
      bitCnt <= 3'h0;
    end else begin
      if (slaveStart) begin
        active <= 1'b1;
        bitCnt <= 3'h0;
      end
      if (lead) begin
        inLatch <= inBit;
        outBit <= shifter[7];
        sckAct <= mstr;
      end
      if (trail) begin
        shifter <= rxByte;
        sckAct <= 1'b0;
        bitCnt <= bitCnt + 3'h1;
        if (bitCnt == `SPM_LAST_BIT) begin
          active <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit buffer. A write while busy queues the byte; the slave keeps
  // resending whatever the shifter holds if software writes too late.
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      txBuf <= 8'h00;
      txPending <= 1'b0;
    end else if (!en) begin
      txPending <= 1'b0;
    end else if (wrData & ~directLoad) begin
      txBuf <= pwdata[7:0];
      txPending <= 1'b1;
    end else if (queuedLoad) begin
      txPending <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive side. At the end of a byte the buffer takes it and the full flag
  // sets together; if the old byte is unread the new one is dropped instead.
  // A set in the same cycle as a clear wins, so no event is lost: a byte
  // that ends while the unread one is being cleared still lands.
  wire rxTake = done & (~rxFull | (rdData & rxArm));
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rxBuf <= 8'h00;
      rxFull <= 1'b0;
      ovr <= 1'b0;
      rxArm <= 1'b0;
      ovrArm <= 1'b0;
    end else begin
      if (rdStat) begin
        rxArm <= rxFull;
        ovrArm <= ovr;
      end else if (rdData) begin
        rxArm <= 1'b0;
        ovrArm <= 1'b0;
      end
      if (done & ~rxTake) begin
        ovr <= 1'b1;
      end else if (rdData & ovrArm) begin
        ovr <= 1'b0;
      end
      if (rxTake) begin
        rxBuf <= rxByte;
        rxFull <= 1'b1;
      end else if (rdData & rxArm) begin
        rxFull <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers. A mode fault forces the port out of master role and
  // disables it, so two masters cannot fight over the clock line.
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rxIe <= CTRL_INIT[`SPM_C_RXIE];
      mstr <= CTRL_INIT[`SPM_C_MSTR];
      clock_polarity <= CTRL_INIT[`SPM_C_CLOCK_POLARITY];
      clock_phase <= CTRL_INIT[`SPM_C_CLOCK_PHASE];
      wom <= CTRL_INIT[`SPM_C_WOM];
      en <= CTRL_INIT[`SPM_C_EN];
      txIe <= CTRL_INIT[`SPM_C_TXIE];
      error_irq_enable <= STAT_INIT[`SPM_S_ERROR_IRQ_ENABLE];
      mode_fault_enable <= STAT_INIT[`SPM_S_MODE_FAULT_ENABLE];
      rateSel <= STAT_INIT[`SPM_S_RATE_HI:`SPM_S_RATE_LO];
    end else begin
      if (wrCtrl) begin
        rxIe <= pwdata[`SPM_C_RXIE];
        mstr <= pwdata[`SPM_C_MSTR];
        clock_polarity <= pwdata[`SPM_C_CLOCK_POLARITY];
        clock_phase <= pwdata[`SPM_C_CLOCK_PHASE];
        wom <= pwdata[`SPM_C_WOM];
        en <= pwdata[`SPM_C_EN];
        txIe <= pwdata[`SPM_C_TXIE];
      end else if (wrData) begin
        txIe <= 1'b0;
      end
      if (wrStat) begin
        error_irq_enable <= pwdata[`SPM_S_ERROR_IRQ_ENABLE];
        mode_fault_enable <= pwdata[`SPM_S_MODE_FAULT_ENABLE];
        rateSel <= pwdata[`SPM_S_RATE_HI:`SPM_S_RATE_LO];
      end
      if (modfEvent) begin
        mstr <= 1'b0;
        en <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode fault flag: cleared by a status read and then a control write.
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_fault_flag <= 1'b0;
      modfArm <= 1'b0;
    end else begin
      if (rdStat) begin
        modfArm <= mode_fault_flag;
      end else if (wrCtrl) begin
        modfArm <= 1'b0;
      end
      if (modfEvent) begin
        mode_fault_flag <= 1'b1;
      end else if (wrCtrl & modfArm) begin
        mode_fault_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins. In wired-or mode a driver only pulls low and leaves high to the
  // pull-up. The slave drives MISO only while selected.
  wire dataOut = clock_phase ? outBit : shifter[7];
  wire mDrive = en & mstr;
  assign sckOut = clock_polarity ^ sckAct;
  assign mosiOut = dataOut;
  assign misoOut = dataOut;
  assign sckOe = mDrive & (~wom | ~sckOut);
  assign mosiOe = mDrive & (~wom | ~mosiOut);
  assign misoOe = sEnabled & (~wom | ~misoOut);

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt requests, separately enabled; errors share the receive one.
  assign rxIrq = (rxIe & rxFull) | (error_irq_enable & (ovr | mode_fault_flag));
  assign txIrq = txIe & ~txPending;

endmodule // spm_port

// [spm_port_chk.sv]
// Checker for spm_port: APB answers, pin ownership, interrupt side effects.
// Assumes a bind from the bench top and the single bus clock domain.
`timescale 1ns/1ps
module spm_port_chk (
  input wire core_clk,
  input wire reset_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire sckOe,
  input wire mosiOe,
  input wire misoOe,
  input wire slaveSelect_n,
  input wire rxIrq,
  input wire txIrq
);
  // Access phase and word index, shared by the bus properties.
  wire acc = psel && penable;
  wire [5:0] idx = paddr[7:2];
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  //////////////////////////////
  // Bus answers; the mapped words sit at indices 0x10 to 0x12.
  a_ready_high: assert property (psel |-> pready)
    else $error("pready low in a transfer");
  a_err_phase: assert property (pslverr |-> acc)
    else $error("pslverr outside access");
  a_err_unmapped: assert property (acc && (idx < 6'h10 || idx > 6'h12) |-> pslverr)
    else $error("unmapped access not refused");
  a_rdata_upper: assert property (prdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  // A falling receive request needs a data read or a settings write before it.
  a_txie_clear: assert property (acc && pwrite && idx == 6'h12 |=> !txIrq)
    else $error("tx request after data write");
  a_rxirq_fall: assert property ($fell(rxIrq) |->
    $past(acc && (pwrite != (idx == 6'h12))))
    else $error("rx request fell without cause");
  // Only one role drives the link at a time.
  a_role_excl: assert property (misoOe |-> !sckOe && !mosiOe)
    else $error("both roles driving");
  a_miso_quiet: assert property (slaveSelect_n [*3] |-> !misoOe)
    else $error("miso driven unselected");
endmodule // spm_port_chk

// [spm_rate_gen.v]
// Master serial clock rate generator: a half-period tick that runs only while run is high.
// Assumes run is held high only while the port is enabled in master role.
`timescale 1ns/1ps
`include "spm_defines.vh"

module spm_rate_gen (
  input wire core_clk,
  input wire reset_n,
  input wire run,
  input wire [1:0] rateSel,
  output reg halfTick
);

  reg [6:0] count;
  reg [6:0] halfLen;

  ////////////////////////////////////////////////////////////////////////////
  // Half period chosen by the rate select bits, fastest first.
  always @* begin
    case (rateSel)
      2'h0: halfLen = `SPM_HALF_DIV2;
      2'h1: halfLen = `SPM_HALF_DIV8;
      2'h2: halfLen = `SPM_HALF_DIV32;
      default: halfLen = `SPM_HALF_DIV128;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // The counter only runs while run is high, so it saves power while the port is disabled or a slave.
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= 7'h00;
      halfTick <= 1'b0;
    end else if (!run) begin
      count <= 7'h00;
      halfTick <= 1'b0;
    end else if (count >= halfLen - 7'h01) begin
      count <= 7'h00;
      halfTick <= 1'b1;
    end else begin
      count <= count + 7'h01;
      halfTick <= 1'b0;
    end
  end

endmodule // spm_rate_gen

// [spm_remote_slave.sv]
// Far-side peripheral model: a byte serial slave for the master tests.
// Assumes the bench drives its select and clock format and resolves pins.
`timescale 1ns/1ps
module spm_remote_slave (
  input wire sck,
  input wire mosi,
  input wire clock_polarity,
  input wire clock_phase,
  input wire sel_n,
  input wire [7:0] txByte,
  output wire miso,
  output logic [7:0] rxByte
);
  logic [7:0] sh = 8'h00;
  logic outBit = 1'b0;
  logic [3:0] cnt = 4'h0;
  //////////////////////////////
  // Deselected, the line floats; the inverse of the last bit shows that.
  assign miso = sel_n ? ~outBit : outBit;
  // Selection loads the byte; in phase 0 the top bit is out before any edge.
  always @(negedge sel_n) begin
    sh = txByte;
    cnt = 4'h0;
    outBit = sh[7];
    if (!clock_phase) sh = sh << 1;
  end
  // Phase 1 shifts out on leading edges, phase 0 on trailing ones.
  always @(posedge sck or negedge sck) begin
    if (!sel_n && ((sck !== clock_polarity) == clock_phase)) begin
      outBit = sh[7];
      sh = sh << 1;
    end else if (!sel_n) begin
      rxByte = {rxByte[6:0], mosi};
      cnt = cnt + 4'h1;
      if (cnt == 4'h8 && clock_phase) begin
        sh = txByte;
        cnt = 4'h0;
      end
    end
  end
endmodule // spm_remote_slave

// [tb_spm_port.sv]
// Testbench for spm_port: register traffic and byte exchanges in both roles.
// Assumes spm_port_chk and spm_remote_slave are compiled before it.
`timescale 1ns/1ps
module tb_spm_port;
  localparam logic [7:0] CT = 8'h40, ST = 8'h44, DT = 8'h48;
  logic core_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, pTx = 8'h00, r, mi, tx, rx, hf;
  logic [31:0] pwdata = 32'h00000000;
  logic tSck = 1'b0, tMosi = 1'b0, devSel_n = 1'b1, remSel_n = 1'b1, clock_polarity, clock_phase, e;
  logic sckPrev = 1'b0;
  logic [1:0] rt;
  logic [27:0] rows [0:3];
  wire [31:0] prdata;
  wire [7:0] pRx;
  wire pready, pslverr, sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe, rxIrq, txIrq, pMiso;
  integer n_fail = 0, total_checks = 0, i, gap = 0, lastGap = 0;
  // Each pin takes the value of whichever side enables its driver.
  wire sck = sckOe ? sckOut : tSck;
  wire mosi = mosiOe ? mosiOut : tMosi;
  wire miso = misoOe ? misoOut : pMiso;
  spm_port u_spm_port (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sckIn(sck), .sckOut(sckOut), .sckOe(sckOe),
    .mosiIn(mosi), .mosiOut(mosiOut), .mosiOe(mosiOe), .misoIn(miso), .misoOut(misoOut),
    .misoOe(misoOe), .slaveSelect_n(devSel_n), .rxIrq(rxIrq), .txIrq(txIrq));
  spm_remote_slave u_spm_remote_slave (.sck(sck), .mosi(mosi), .clock_polarity(clock_polarity), .clock_phase(clock_phase),
    .sel_n(remSel_n), .txByte(pTx), .miso(pMiso), .rxByte(pRx));
  //////////////////////////////
  // The bus clock runs at 125 MHz.
  always #4 core_clk = ~core_clk;
  // Cycles between serial clock changes give the master half period.
  always @(posedge core_clk) begin
    sckPrev <= sckOut;
    gap <= (sckOut !== sckPrev) ? 1 : gap + 1;
    if (sckOut !== sckPrev) lastGap <= gap;
  end
  // Compare one byte result.
  task chk8(input string n, input logic [7:0] x, input logic [7:0] g);
    total_checks++;
    if (g !== x) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask
  // Print the counts and the verdict, then stop.
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // One APB transfer; the request holds until pready is sampled high.
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    integer k;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      final_report;
    end
  endtask
  // Read status until a bit sets; a hang ends the run.
  task poll(input integer b);
    integer j;
    r = 8'h00;
    for (j = 0; j < 1500 && r[b] !== 1'b1; j++) apb(1'b0, ST, 8'h00);
    if (r[b] !== 1'b1) begin
      n_fail++;
      final_report;
    end
  endtask
  // The bench as remote master in the phase of clock_phase, half period of four bus cycles.
  task sx(input logic [7:0] mo);
    devSel_n <= 1'b0;
    tMosi <= mo[7];
    for (int b = 7; b >= 0; b--) begin
      repeat (4) @(posedge core_clk);
      tSck <= ~clock_polarity;
      if (clock_phase) tMosi <= mo[b];
      repeat (4) @(posedge core_clk);
      mi[b] = miso;
      tSck <= clock_polarity;
      if (!clock_phase && b > 0) tMosi <= mo[b-1];
    end
    repeat (4) @(posedge core_clk);
    devSel_n <= 1'b1;
    tMosi <= ~mo[0];
  endtask
  //////////////////////////////
  // Rows: rate, polarity, phase, byte sent, byte answered, half period.
  initial begin
    rows[0] = {2'h0, 1'h0, 1'h1, 8'hA5, 8'h3C, 8'h01};
    rows[1] = {2'h1, 1'h0, 1'h0, 8'h81, 8'h7E, 8'h04};
    rows[2] = {2'h2, 1'h1, 1'h1, 8'hC3, 8'h5A, 8'h10};
    rows[3] = {2'h3, 1'h1, 1'h0, 8'h0F, 8'hF0, 8'h40};
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    for (i = 0; i < 4; i++) begin
      {rt, clock_polarity, clock_phase, tx, rx, hf} = rows[i];
      tSck <= clock_polarity;
      pTx <= rx;
      apb(1'b1, CT, {3'h1, clock_polarity, clock_phase, 3'h0});
      apb(1'b1, ST, {6'h00, rt});
      apb(1'b1, CT, {3'h1, clock_polarity, clock_phase, 3'h2});
      remSel_n <= 1'b0;
      apb(1'b1, DT, tx);
      poll(7);
      chk8("half period", hf, lastGap[7:0]);
      chk8("remote rx", tx, pRx);
      apb(1'b0, DT, 8'h00);
      chk8("rx data", rx, r);
      remSel_n <= 1'b1;
    end
    // Two bytes back to back; the second overruns the unread first.
    clock_polarity = 1'b0;
    clock_phase = 1'b1;
    tSck <= 1'b0;
    pTx <= 8'h11;
    apb(1'b1, CT, 8'hA8);
    apb(1'b1, ST, 8'h40);
    apb(1'b1, CT, 8'hAA);
    remSel_n <= 1'b0;
    apb(1'b1, DT, 8'hAA);
    apb(1'b0, ST, 8'h00);
    chk8("tx empty", 8'h01, {7'h00, r[3]});
    apb(1'b1, DT, 8'hBB);
    apb(1'b0, ST, 8'h00);
    chk8("tx queued", 8'h00, {7'h00, r[3]});
    poll(5);
    chk8("rx request", 8'h01, {7'h00, rxIrq});
    apb(1'b0, DT, 8'h00);
    chk8("kept byte", 8'h11, r);
    chk8("remote second", 8'hBB, pRx);
    apb(1'b0, ST, 8'h00);
    chk8("rx full clear", 8'h00, {7'h00, r[7]});
    remSel_n <= 1'b1;
    // The transmit request is masked by a data write.
    apb(1'b1, CT, 8'h23);
    apb(1'b0, CT, 8'h00);
    chk8("tx request", 8'h01, {7'h00, txIrq});
    apb(1'b1, DT, 8'h00);
    apb(1'b0, CT, 8'h00);
    chk8("control", 8'h22, r);
    poll(7);
    apb(1'b0, DT, 8'h00);
    apb(1'b0, 8'h4C, 8'h00);
    chk8("unmapped", 8'h01, {r[7:1], e});
    // Slave role with a slow rate setting and a faster pin clock.
    apb(1'b1, CT, 8'h08);
    apb(1'b1, ST, 8'h03);
    apb(1'b1, CT, 8'h0A);
    apb(1'b1, DT, 8'h96);
    sx(8'h5C);
    chk8("slave out", 8'h96, mi);
    apb(1'b0, DT, 8'h00);
    chk8("slave rx", 8'h5C, r);
    apb(1'b0, ST, 8'h00);
    chk8("rx full held", 8'h01, {7'h00, r[7]});
    apb(1'b0, DT, 8'h00);
    apb(1'b0, ST, 8'h00);
    chk8("rx full off", 8'h00, {7'h00, r[7]});
    sx(8'h3A);
    chk8("old byte resent", 8'h5C, mi);
    apb(1'b0, ST, 8'h00);
    apb(1'b0, DT, 8'h00);
    chk8("slave rx two", 8'h3A, r);
    // Slave in phase zero: the select fall starts the byte, bit 7 shows first.
    clock_phase = 1'b0;
    apb(1'b1, CT, 8'h00);
    apb(1'b1, CT, 8'h02);
    apb(1'b1, DT, 8'h69);
    sx(8'hC5);
    chk8("phase 0 out", 8'h69, mi);
    apb(1'b0, ST, 8'h00);
    apb(1'b0, DT, 8'h00);
    chk8("phase 0 rx", 8'hC5, r);
    // A reset in mid-run restores the register defaults.
    reset_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    apb(1'b0, CT, 8'h00);
    chk8("control reset", 8'h28, r);
    apb(1'b0, ST, 8'h00);
    chk8("status reset", 8'h08, r);
    final_report;
  end
endmodule // tb_spm_port

bind spm_port spm_port_chk u_spm_port_chk (.core_clk(core_clk), .reset_n(reset_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sckOe(sckOe), .mosiOe(mosiOe), .misoOe(misoOe),
  .slaveSelect_n(slaveSelect_n), .rxIrq(rxIrq), .txIrq(txIrq));
